// ==== common/esr_defs.svh ====
// Constants of the event status reporting block: bit positions,
// reset values, error classes and reply characters.
// Assumes inclusion by bare name from the design file only.
`ifndef ESR_DEFS_SVH
`define ESR_DEFS_SVH

// -----------------------------------------------------------------
// Event latch bit positions
// -----------------------------------------------------------------
`define ESR_BIT_OPC        0
`define ESR_BIT_QRY_ERR    2
`define ESR_BIT_DEV_ERR    3
`define ESR_BIT_EXE_ERR    4
`define ESR_BIT_CMD_ERR    5

// -----------------------------------------------------------------
// Status byte bit positions
// -----------------------------------------------------------------
`define STB_BIT_ERR_AVAIL  2
`define STB_BIT_QUES_SUM   3
`define STB_BIT_MSG_AVAIL  4
`define STB_BIT_EVENT_SUM  5
`define STB_BIT_OPER_SUM   7

// -----------------------------------------------------------------
// Questionable latch bits for supply errors
// -----------------------------------------------------------------
`define QUES_BIT_VOLT_ERR  0
`define QUES_BIT_CURR_ERR  1

// -----------------------------------------------------------------
// Reset values
// -----------------------------------------------------------------
`define ESE_RESET          8'h00
`define ESR_RESET          8'h00
`define LATCH_RESET        8'h00

// -----------------------------------------------------------------
// Error code classes (code divided by one hundred)
// -----------------------------------------------------------------
`define ERR_CLASS_CMD      4'h1
`define ERR_CLASS_EXE      4'h2
`define ERR_CLASS_DEV      4'h3
`define ERR_CLASS_QRY      4'h4

// -----------------------------------------------------------------
// Reply characters and lengths
// -----------------------------------------------------------------
`define CHR_COMMA          8'h2C
`define CHR_SLASH          8'h2F
`define CHR_SPACE          8'h20
`define CHR_LF             8'h0A
`define CHR_DIGIT_HI       4'h3
`define IDN_LEN            6'h2B

`endif

// ==== common/esr_pkg.sv ====
// Types of the event status reporting block.
// Assumes nothing of its surroundings.
package esr_pkg;

  typedef enum logic [1:0] {
    ESR_IDLE = 2'b01,
    ESR_SEND = 2'b10
  } esr_state_t;

  typedef enum logic [1:0] {
    ESR_KIND_DEC = 2'b01,
    ESR_KIND_IDN = 2'b10
  } esr_kind_t;

endpackage : esr_pkg

// ==== verilog/esr_status.sv ====
// Event status latch, enable mask, status byte, error queue and
// ASCII reply engine of a remotely programmed instrument.
// Assumes a command parser that gives one-cycle command pulses.
//
// Operation
// R1: Clear-status empties the error queue.
// R2: Clear-status drops pending completion tracking to the idle state.
// R3: Clear-status zeroes event, operation, questionable latches; masks untouched.
// R4: Enable mask takes any 0..255 value and resets to zero.
// R5: Status byte bit 5 is OR of latch bits with mask bits set.
// R6: Mask query returns the stored mask unchanged.
// R7: Latch bits: 5 command, 4 execution, 3 device, 2 query, 0 complete.
// R8: Latch query returns the latch value, then clears the latch.
// R9: Error codes 1xx set the command error bit.
// R10: Error codes 2xx set the execution error bit.
// R11: Error codes 3xx set the device-dependent error bit.
// R12: Voltage or current error sets questionable bit and device error bit.
// R13: Error codes 4xx set the query error bit.
// R14: Identity reply: maker, model rating date, serial, firmware, comma separated.
// R15: Calibration date printed MM/DD/YYYY.
// R16: Serial number printed as exactly six digits.
// R17: Completion command clears bit 0; bit 0 sets once all work is idle.
// R18: Integer replies go out as ASCII decimal text.
`timescale 1ns/1ps
`default_nettype none
`include "esr_defs.svh"

module esr_status #(
  parameter int          ERRQ_DEPTH  = 8,
  parameter logic [47:0] MAKER_NAME  = "VENDOR",   // Arbitrary value
  parameter logic [47:0] MODEL_NAME  = "MODEL1",   // Arbitrary value
  parameter logic [39:0] RATING_TEXT = "00-00",
  parameter logic [31:0] FW_TEXT     = "1.00",
  parameter logic [7:0]  CAL_MONTH   = 8'h01,
  parameter logic [7:0]  CAL_DAY     = 8'h01,
  parameter logic [15:0] CAL_YEAR    = 16'h2000,
  parameter logic [23:0] SERIAL_BCD  = 24'h000000
) (
  input  wire logic       i_clock,
  input  wire logic       i_reset,
  input  wire logic       i_cmd_clear_status,
  input  wire logic       i_cmd_mask_write,
  input  wire logic [7:0] i_mask_value,
  input  wire logic       i_qry_mask,
  input  wire logic       i_qry_latch,
  input  wire logic       i_cmd_op_complete,
  input  wire logic       i_qry_op_complete,
  input  wire logic       i_qry_identity,
  input  wire logic       i_ops_idle,
  input  wire logic       i_error_valid,
  input  wire logic [9:0] i_error_code,
  input  wire logic       i_error_pop,
  input  wire logic       i_volt_error,
  input  wire logic       i_curr_error,
  input  wire logic [7:0] i_ques_events,
  input  wire logic [7:0] i_ques_enable,
  input  wire logic [7:0] i_oper_events,
  input  wire logic [7:0] i_oper_enable,
  input  wire logic       i_reply_ready,
  output logic            o_reply_valid,
  output logic      [7:0] o_reply_data,
  output logic            o_busy,
  output logic      [7:0] o_status_byte,
  output logic      [7:0] o_event_latch,
  output logic      [7:0] o_event_mask,
  output logic      [9:0] o_error_code,
  output logic            o_error_avail
);

  // -----------------------------------------------------------------
  // Helpers
  // -----------------------------------------------------------------
  localparam int QW = $clog2(ERRQ_DEPTH);

  function automatic logic [7:0] bcd_chr(input logic [3:0] d);
    bcd_chr = {`CHR_DIGIT_HI, d};
  endfunction : bcd_chr

  // Leading zeros suppressed; terminator appended. Returns {len, chars}.
  function automatic logic [34:0] dec_text(input logic [7:0] v);
    logic [3:0] h;
    logic [3:0] t;
    logic [3:0] o;
    h = 4'(v / 8'd100);
    t = 4'((v / 8'd10) % 8'd10);
    o = 4'(v % 8'd10);
    if (v >= 8'd100) begin
      dec_text = {3'd4, bcd_chr(h), bcd_chr(t), bcd_chr(o), `CHR_LF};
    end else if (v >= 8'd10) begin
      dec_text = {3'd3, bcd_chr(t), bcd_chr(o), `CHR_LF, 8'h00};
    end else begin
      dec_text = {3'd2, bcd_chr(o), `CHR_LF, 16'h0000};
    end
  endfunction : dec_text

  function automatic logic [7:0] idn_chr(input logic [5:0] idx);
    int k;
    k = int'(idx);
    if (k <= 5) begin
      idn_chr = MAKER_NAME[8*(5-k) +: 8];                     // R14
    end else if (k == 6 || k == 30 || k == 37) begin
      idn_chr = `CHR_COMMA;                                   // R14
    end else if (k <= 12) begin
      idn_chr = MODEL_NAME[8*(12-k) +: 8];
    end else if (k == 13 || k == 19) begin
      idn_chr = `CHR_SPACE;
    end else if (k <= 18) begin
      idn_chr = RATING_TEXT[8*(18-k) +: 8];
    end else if (k <= 21) begin
      idn_chr = bcd_chr(CAL_MONTH[4*(21-k) +: 4]);            // R15
    end else if (k == 22 || k == 25) begin
      idn_chr = `CHR_SLASH;                                   // R15
    end else if (k <= 24) begin
      idn_chr = bcd_chr(CAL_DAY[4*(24-k) +: 4]);              // R15
    end else if (k <= 29) begin
      idn_chr = bcd_chr(CAL_YEAR[4*(29-k) +: 4]);             // R15
    end else if (k <= 36) begin
      idn_chr = bcd_chr(SERIAL_BCD[4*(36-k) +: 4]);           // R16
    end else if (k <= 41) begin
      idn_chr = FW_TEXT[8*(41-k) +: 8];
    end else begin
      idn_chr = `CHR_LF;
    end
  endfunction : idn_chr

  // -----------------------------------------------------------------
  // State
  // -----------------------------------------------------------------
  esr_pkg::esr_state_t state,       next_state;
  esr_pkg::esr_kind_t  kind,        next_kind;
  logic [7:0]          mask,        next_mask;
  logic [7:0]          latch,       next_latch;
  logic [7:0]          ques_latch,  next_ques_latch;
  logic [7:0]          oper_latch,  next_oper_latch;
  logic                opc_pending, next_opc_pending;
  logic [5:0]          idx,         next_idx;
  logic [5:0]          len,         next_len;
  logic [31:0]         dec_buf,     next_dec_buf;
  logic                next_reply_valid;
  logic [7:0]          next_reply_data;
  logic [7:0]          next_status_byte;
  logic [9:0]          next_error_code;
  logic [QW-1:0]       wptr,        next_wptr;
  logic [QW-1:0]       rptr,        next_rptr;
  logic [QW:0]         count,       next_count;
  logic [9:0]          queue [ERRQ_DEPTH];
  logic                push;

  // -----------------------------------------------------------------
  // Next-state logic
  // -----------------------------------------------------------------
  always_comb begin
    logic [7:0]  ev;
    logic [3:0]  ecls;
    logic [34:0] dt;
    logic        start;
    logic [7:0]  reply_val;
    ev               = 8'h00;
    ecls             = 4'(i_error_code / 10'd100);
    dt               = 35'h0;
    start            = 1'b0;
    reply_val        = 8'h00;
    next_state       = state;
    next_kind        = kind;
    next_mask        = mask;
    next_ques_latch  = ques_latch;
    next_oper_latch  = oper_latch;
    next_opc_pending = opc_pending;
    next_idx         = idx;
    next_len         = len;
    next_dec_buf     = dec_buf;
    next_reply_valid = o_reply_valid;
    next_reply_data  = o_reply_data;
    next_latch       = latch;
    next_wptr        = wptr;
    next_rptr        = rptr;
    next_count       = count;
    push             = 1'b0;

    // Events caught this cycle
    if (i_error_valid) begin
      if (ecls == `ERR_CLASS_CMD) ev[`ESR_BIT_CMD_ERR] = 1'b1;   // R9
      if (ecls == `ERR_CLASS_EXE) ev[`ESR_BIT_EXE_ERR] = 1'b1;   // R10
      if (ecls == `ERR_CLASS_DEV) ev[`ESR_BIT_DEV_ERR] = 1'b1;   // R11
      if (ecls == `ERR_CLASS_QRY) ev[`ESR_BIT_QRY_ERR] = 1'b1;   // R13
    end
    if (i_volt_error || i_curr_error) begin
      ev[`ESR_BIT_DEV_ERR] = 1'b1;                              // R12
    end
    if (opc_pending && i_ops_idle && !i_cmd_op_complete && !i_cmd_clear_status) begin
      ev[`ESR_BIT_OPC] = 1'b1;                                  // R17
      next_opc_pending = 1'b0;
    end

    // Query decode, only while no reply is going out
    if (state == esr_pkg::ESR_IDLE) begin
      if (i_qry_latch) begin
        start      = 1'b1;
        reply_val  = latch;                                     // R8
        next_latch = `ESR_RESET;                                // R8
      end else if (i_qry_mask) begin
        start     = 1'b1;
        reply_val = mask;                                       // R6
      end else if (i_qry_op_complete) begin
        start     = 1'b1;
        reply_val = {7'h00, !opc_pending};
      end else if (i_qry_identity) begin
        next_state       = esr_pkg::ESR_SEND;
        next_kind        = esr_pkg::ESR_KIND_IDN;
        next_len         = `IDN_LEN;
        next_reply_data  = idn_chr(6'h00);                      // R14
        next_reply_valid = 1'b1;
        next_idx         = 6'h01;
      end
      if (start) begin
        dt               = dec_text(reply_val);                 // R18
        next_state       = esr_pkg::ESR_SEND;
        next_kind        = esr_pkg::ESR_KIND_DEC;
        next_len         = {3'b000, dt[34:32]};
        next_dec_buf     = {dt[23:0], 8'h00};
        next_reply_data  = dt[31:24];
        next_reply_valid = 1'b1;
        next_idx         = 6'h01;
      end
    end else if (o_reply_valid && i_reply_ready) begin
      if (idx == len) begin
        next_reply_valid = 1'b0;
        next_state       = esr_pkg::ESR_IDLE;
      end else begin
        next_idx = idx + 6'h01;
        if (kind == esr_pkg::ESR_KIND_IDN) begin
          next_reply_data = idn_chr(idx);
        end else begin
          next_reply_data = dec_buf[31:24];
          next_dec_buf    = {dec_buf[23:0], 8'h00};
        end
      end
    end

    if (i_cmd_mask_write) begin
      next_mask = i_mask_value;                                 // R4
    end
    if (i_cmd_op_complete) begin
      next_latch[`ESR_BIT_OPC] = 1'b0;                          // R17
      next_opc_pending         = 1'b1;                          // R17
    end
    if (i_cmd_clear_status) begin
      next_latch       = `ESR_RESET;                            // R3
      next_ques_latch  = `LATCH_RESET;                          // R3
      next_oper_latch  = `LATCH_RESET;                          // R3
      next_opc_pending = 1'b0;                                  // R2
      next_count       = '0;                                    // R1
      next_rptr        = wptr;                                  // R1
    end

    // Setting wins over every clear in the same cycle, except on bit 0, where clear-status and the completion command win
    next_latch      = next_latch | ev;                          // R7
    next_oper_latch = next_oper_latch | i_oper_events;
    next_ques_latch = next_ques_latch | i_ques_events;
    next_ques_latch[`QUES_BIT_VOLT_ERR] = next_ques_latch[`QUES_BIT_VOLT_ERR] | i_volt_error;
    next_ques_latch[`QUES_BIT_CURR_ERR] = next_ques_latch[`QUES_BIT_CURR_ERR] | i_curr_error;

    // Error queue; a full queue drops the newest code
    if (i_error_pop && count != '0 && !i_cmd_clear_status) begin
      next_rptr  = rptr + 1'b1;
      next_count = next_count - 1'b1;
    end
    if (i_error_valid && next_count != (QW+1)'(ERRQ_DEPTH)) begin
      push       = 1'b1;
      next_wptr  = wptr + 1'b1;
      next_count = next_count + 1'b1;
    end

    next_status_byte = 8'h00;
    next_status_byte[`STB_BIT_ERR_AVAIL] = next_count != '0;
    next_status_byte[`STB_BIT_QUES_SUM]  = |(next_ques_latch & i_ques_enable);
    next_status_byte[`STB_BIT_MSG_AVAIL] = next_reply_valid;
    next_status_byte[`STB_BIT_EVENT_SUM] = |(next_latch & next_mask);   // R5
    next_status_byte[`STB_BIT_OPER_SUM]  = |(next_oper_latch & i_oper_enable);
    // Head shown at once, even when written this cycle; empty shows zero
    next_error_code = (next_count == '0) ? 10'h000 :
                      (push && next_rptr == wptr) ? i_error_code : queue[next_rptr];
  end

  // -----------------------------------------------------------------
  // Registers
  // -----------------------------------------------------------------
  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      state         <= esr_pkg::ESR_IDLE;
      kind          <= esr_pkg::ESR_KIND_DEC;
      mask          <= `ESE_RESET;                              // R4
      latch         <= `ESR_RESET;
      ques_latch    <= `LATCH_RESET;
      oper_latch    <= `LATCH_RESET;
      opc_pending   <= 1'b0;
      idx           <= 6'h00;
      len           <= 6'h00;
      dec_buf       <= 32'h00000000;
      o_reply_valid <= 1'b0;
      o_reply_data  <= 8'h00;
      o_status_byte <= 8'h00;
      wptr          <= '0;
      rptr          <= '0;
      count         <= '0;
      o_error_code  <= 10'h000;
    end else begin
      state         <= next_state;
      kind          <= next_kind;
      mask          <= next_mask;
      latch         <= next_latch;
      ques_latch    <= next_ques_latch;
      oper_latch    <= next_oper_latch;
      opc_pending   <= next_opc_pending;
      idx           <= next_idx;
      len           <= next_len;
      dec_buf       <= next_dec_buf;
      o_reply_valid <= next_reply_valid;
      o_reply_data  <= next_reply_data;
      o_status_byte <= next_status_byte;
      wptr          <= next_wptr;
      rptr          <= next_rptr;
      count         <= next_count;
      o_error_code  <= next_error_code;
    end
  end

  // Queue storage needs no reset; unread slots are never shown valid
  always_ff @(posedge i_clock) begin
    if (push) begin
      queue[wptr] <= i_error_code;
    end
  end

  assign o_busy        = (state == esr_pkg::ESR_SEND);
  assign o_event_latch = latch;
  assign o_event_mask  = mask;
  assign o_error_avail = (count != '0);

endmodule : esr_status

`default_nettype wire

// ==== testbench/esr_host.sv ====
// Reply consumer standing for the remote controller.
// Assumes replies offered as valid/ready bytes on i_clock.
`timescale 1ns/1ps
`default_nettype none

module esr_host (
  input  wire logic       i_clock,
  input  wire logic       i_slow,
  input  wire logic       i_valid,
  input  wire logic [7:0] i_data,
  output logic            o_ready
);
  logic [7:0] rx [$];
  logic       tog = 1'b0;

  // -----------------------------------------------------------------
  // Acceptance
  // -----------------------------------------------------------------
  // Slow mode stalls every other cycle so each byte must stand
  always @(negedge i_clock) begin
    tog     <= ~tog;
    o_ready <= i_slow ? tog : 1'b1;
  end

  always @(posedge i_clock) begin
    if (i_valid && o_ready) begin
      rx.push_back(i_data);
    end
  end
endmodule : esr_host

`default_nettype wire

// ==== testbench/esr_status_chk.sv ====
// Port checker of the event status block.
// Assumes binding to esr_status, one clock domain.
`timescale 1ns/1ps
`default_nettype none

module esr_status_chk (
  input wire logic       i_clock,
  input wire logic       i_reset,
  input wire logic       i_cmd_clear_status,
  input wire logic       i_cmd_mask_write,
  input wire logic [7:0] i_mask_value,
  input wire logic       i_qry_latch,
  input wire logic       i_cmd_op_complete,
  input wire logic       i_error_valid,
  input wire logic [9:0] i_error_code,
  input wire logic       i_volt_error,
  input wire logic       i_curr_error,
  input wire logic       i_reply_ready,
  input wire logic       o_reply_valid,
  input wire logic [7:0] o_reply_data,
  input wire logic       o_busy,
  input wire logic [7:0] o_status_byte,
  input wire logic [7:0] o_event_latch,
  input wire logic [7:0] o_event_mask,
  input wire logic       o_error_avail
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_reset);

  // -----------------------------------------------------------------
  // Helpers
  // -----------------------------------------------------------------
  logic       quiet;
  logic [3:0] cmap;
  // Events win over clears, so clear checks need a quiet cycle
  assign quiet = !i_error_valid && !i_volt_error && !i_curr_error;
  assign cmap  = (i_error_code >= 10'h064 && i_error_code < 10'h1F4) ?
                 4'h8 >> ((i_error_code / 10'h064) - 10'h001) : 4'h0;

  sequence s_latch_taken;
    i_qry_latch && !o_busy && quiet;
  endsequence
  sequence s_reply_held;
    o_reply_valid && !i_reply_ready;
  endsequence

  // -----------------------------------------------------------------
  // Assertions
  // -----------------------------------------------------------------
  AST_MASK_WRITE: assert property (
    i_cmd_mask_write |=> o_event_mask == $past(i_mask_value))
    else $error("mask write not stored");
  AST_MASK_HOLD: assert property (
    !i_cmd_mask_write |=> $stable(o_event_mask))
    else $error("mask changed without a write");
  AST_SUMMARY: assert property (
    $stable(o_event_latch) && $stable(o_event_mask)
    |-> o_status_byte[5] == |(o_event_latch & o_event_mask))
    else $error("event summary bit wrong");
  AST_CLEAR: assert property (
    i_cmd_clear_status && quiet |=> o_event_latch == 8'h00 && !o_error_avail)
    else $error("clear left status behind");
  AST_LATCH_QRY: assert property (
    s_latch_taken |=> o_reply_valid && o_event_latch[7:1] == 7'h00)
    else $error("latch query did not clear");
  AST_ERR_CLASS: assert property (
    i_error_valid && cmap != 4'h0 |=> (o_event_latch[5:2] & $past(cmap)) == $past(cmap))
    else $error("error class bit not set");
  AST_SUPPLY_ERR: assert property (
    i_volt_error || i_curr_error |=> o_event_latch[3])
    else $error("supply error did not set device bit");
  AST_OPC_CLEAR: assert property (
    i_cmd_op_complete |=> !o_event_latch[0])
    else $error("completion bit not cleared");
  AST_UNUSED_BITS: assert property (
    o_event_latch[7:6] == 2'b00 && !o_event_latch[1])
    else $error("unused latch bit set");
  AST_REPLY_HOLD: assert property (
    s_reply_held |=> o_reply_valid && $stable(o_reply_data))
    else $error("reply byte dropped before acceptance");
endmodule : esr_status_chk

`default_nettype wire

// ==== testbench/tb_event_status_reporting.sv ====
// Self-checking bench of the event status block.
// Assumes the reply consumer model and the bound port checker.
`timescale 1ns/1ps
`default_nettype none

module tb_event_status_reporting;
  localparam logic [10:0] CLS = 11'h001, MSK = 11'h002, QM = 11'h004, QL = 11'h008;
  localparam logic [10:0] OPC = 11'h010, QO = 11'h020, QI = 11'h040, ERR = 11'h080;
  localparam logic [10:0] POP = 11'h100, VLT = 11'h200, CUR = 11'h400;
  logic        i_clock = 1'b0;
  logic        i_reset = 1'b1;
  logic [10:0] cmd = 11'h000;
  logic [7:0]  i_mask_value = 8'h00;
  logic [9:0]  i_error_code = 10'h000;
  logic        i_ops_idle = 1'b1;
  logic [7:0]  i_ques_events = 8'h00, i_ques_enable = 8'h00;
  logic [7:0]  i_oper_events = 8'h00, i_oper_enable = 8'h00;
  logic        slow = 1'b0;
  logic        i_reply_ready, o_reply_valid, o_busy, o_error_avail;
  logic [7:0]  o_reply_data, o_status_byte, o_event_latch, o_event_mask;
  logic [9:0]  o_error_code;
  int          n_mismatch = 0;
  int          comparisons = 0;
  int          cycles = 0;

  esr_status #(
    .MAKER_NAME ("MAKERX"), // Arbitrary value
    .MODEL_NAME ("UNIT01"), // Arbitrary value
    .RATING_TEXT("10-20"), .FW_TEXT("2.50"), .CAL_MONTH(8'h09),
    .CAL_DAY(8'h30), .CAL_YEAR(16'h2001), .SERIAL_BCD(24'h123456)
  ) dut (
    .i_clock, .i_reset, .i_cmd_clear_status(cmd[0]), .i_cmd_mask_write(cmd[1]),
    .i_mask_value, .i_qry_mask(cmd[2]), .i_qry_latch(cmd[3]),
    .i_cmd_op_complete(cmd[4]), .i_qry_op_complete(cmd[5]), .i_qry_identity(cmd[6]),
    .i_ops_idle, .i_error_valid(cmd[7]), .i_error_code, .i_error_pop(cmd[8]),
    .i_volt_error(cmd[9]), .i_curr_error(cmd[10]), .i_ques_events, .i_ques_enable,
    .i_oper_events, .i_oper_enable, .i_reply_ready, .o_reply_valid, .o_reply_data,
    .o_busy, .o_status_byte, .o_event_latch, .o_event_mask, .o_error_code,
    .o_error_avail
  );

  esr_host u_host (
    .i_clock, .i_slow(slow), .i_valid(o_reply_valid), .i_data(o_reply_data),
    .o_ready(i_reply_ready)
  );

  always #20 i_clock = ~i_clock;

  // -----------------------------------------------------------------
  // Helpers
  // -----------------------------------------------------------------
  always @(posedge i_clock) begin
    cycles++;
    if (cycles == 5000) begin
      n_mismatch++;
      results();
    end
  end

  task automatic results;
    $display("comparisons=%0d mismatches=%0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : results

  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp

  task automatic cmp_s(input string got, input string exp);
    comparisons++;
    if (got != exp) begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp_s

  // Extra settle cycle; registered status updates on the same edge as the latch
  task automatic pulse(input logic [10:0] m);
    @(negedge i_clock) cmd = m;
    @(negedge i_clock) cmd = 11'h000;
    @(negedge i_clock);
  endtask : pulse

  task automatic ask(input logic [10:0] m, input logic [10:0] m2, input string exp);
    string s = "";
    u_host.rx.delete();
    pulse(m);
    if (m2 != 11'h000) pulse(m2);
    for (int k = 0; k < 300 && o_busy !== 1'b0; k++) @(negedge i_clock);
    foreach (u_host.rx[k]) s = {s, string'(u_host.rx[k])};
    cmp_s(s, exp);
  endtask : ask

  // -----------------------------------------------------------------
  // Scenarios
  // -----------------------------------------------------------------
  task automatic t_reset;
    cmp(o_event_mask, 8'h00);
    cmp(o_event_latch, 8'h00);
    cmp(o_status_byte, 8'h00);
    cmp(o_error_code, 10'h000);
    $display("test reset done");
  endtask : t_reset

  task automatic t_mask;
    logic [7:0] v [3] = '{8'h00, 8'hFF, 8'h3C};
    string      e [3] = '{"0\n", "255\n", "60\n"};
    for (int k = 0; k < 3; k++) begin
      i_mask_value = v[k];
      pulse(MSK);
      cmp(o_event_mask, v[k]);
      ask(QM, 11'h000, e[k]);
      cmp(o_event_mask, v[k]);
    end
    $display("test mask done");
  endtask : t_mask

  task automatic t_err;
    logic [9:0] c [4] = '{10'h096, 10'h0FA, 10'h15E, 10'h1C2};
    string      e [4] = '{"32\n", "16\n", "8\n", "4\n"};
    for (int k = 0; k < 4; k++) begin
      i_error_code = c[k];
      pulse(ERR);
      cmp(o_status_byte[5], 1'b1);
      ask(QL, 11'h000, e[k]);
      cmp(o_event_latch, 8'h00);
      cmp(o_status_byte[5], 1'b0);
    end
    cmp(o_error_code, 10'h096);
    pulse(POP);
    cmp(o_error_code, 10'h0FA);
    pulse(VLT);
    ask(QL, 11'h000, "8\n");
    pulse(CUR);
    ask(QL, 11'h000, "8\n");
    $display("test errors done");
  endtask : t_err

  task automatic t_opc;
    i_ops_idle = 1'b0;
    pulse(OPC);
    cmp(o_event_latch[0], 1'b0);
    ask(QO, 11'h000, "0\n");
    i_ops_idle = 1'b1;
    repeat (2) @(negedge i_clock);
    cmp(o_event_latch[0], 1'b1);
    ask(QO, 11'h000, "1\n");
    ask(QL, 11'h000, "1\n");
    i_ops_idle = 1'b0;
    pulse(OPC);
    pulse(CLS);
    i_ops_idle = 1'b1;
    repeat (3) @(negedge i_clock);
    cmp(o_event_latch[0], 1'b0);
    ask(QO, 11'h000, "1\n");
    $display("test completion done");
  endtask : t_opc

  task automatic t_clear;
    i_error_code = 10'h12C;
    pulse(ERR);
    i_ques_enable = 8'hFF;
    i_oper_enable = 8'hFF;
    i_ques_events = 8'h04;
    i_oper_events = 8'h01;
    @(negedge i_clock);
    i_ques_events = 8'h00;
    i_oper_events = 8'h00;
    @(negedge i_clock);
    cmp(o_status_byte, 8'hAC);
    pulse(CLS);
    cmp(o_event_latch, 8'h00);
    cmp(o_status_byte, 8'h00);
    cmp(o_error_avail, 1'b0);
    cmp(o_event_mask, 8'h3C);
    $display("test clear done");
  endtask : t_clear

  // Latch query sent mid-reply must be ignored and leave the latch
  task automatic t_idn;
    i_error_code = 10'h096;
    pulse(ERR);
    cmp(o_error_code, 10'h096);
    slow = 1'b1;
    ask(QI, QL, "MAKERX,UNIT01 10-20 09/30/2001,123456,2.50\n");
    cmp(o_event_latch, 8'h20);
    slow = 1'b0;
    ask(QL, 11'h000, "32\n");
    $display("test identity done");
  endtask : t_idn

  initial begin
    repeat (5) @(negedge i_clock);
    i_reset = 1'b0;
    t_reset();
    t_mask();
    t_err();
    t_opc();
    t_clear();
    t_idn();
    i_reset = 1'b1;
    @(negedge i_clock);
    i_reset = 1'b0;
    t_reset();
    results();
  end
endmodule : tb_event_status_reporting

bind esr_status esr_status_chk u_chk (
  .i_clock, .i_reset, .i_cmd_clear_status, .i_cmd_mask_write, .i_mask_value,
  .i_qry_latch, .i_cmd_op_complete, .i_error_valid, .i_error_code, .i_volt_error,
  .i_curr_error, .i_reply_ready, .o_reply_valid, .o_reply_data, .o_busy,
  .o_status_byte, .o_event_latch, .o_event_mask, .o_error_avail
);

`default_nettype wire
